/* File: verilog/mbs_pkg.sv */
// constants and state encoding for the motor brake sequencer
package mbs_pkg;
    // control clock
    localparam int unsigned CLK_HZ        = 125_000_000;
    // hold times count in 10 ms steps (0.01 s)
    localparam int unsigned TIME_LSB_MS   = 10;
    localparam int unsigned TIME_TICK_CYC = CLK_HZ / 1000 * TIME_LSB_MS;
    // setting widths and ranges (time 0.01 s, speed 0.1 rpm, current 0.1 %)
    localparam int unsigned TIME_W        = 12;
    localparam int unsigned SPD_W         = 13;
    localparam int unsigned PCT_W         = 11;
    localparam logic [11:0] TIME_MAX      = 12'hBB8; // 30.00 s
    localparam logic [12:0] SPD_MAX       = 13'h1388; // 500.0 rpm
    localparam logic [10:0] PCT_MAX       = 11'h5DC; // 150.0 %
    localparam logic [10:0] PCT_RESET     = 11'h0C8; // 20.0 %

    // sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE       = 6'h01,
        ST_EXCITE     = 6'h02,
        ST_OPEN_HOLD  = 6'h04,
        ST_RUN        = 6'h08,
        ST_CLOSING    = 6'h10,
        ST_CLOSE_HOLD = 6'h20
    } mbs_state_t;
endpackage : mbs_pkg

/* File: verilog/mbs_tmr_if.sv */
// link between the sequencer and its hold timer
interface mbs_tmr_if;
    logic                             load;
    logic [mbs_pkg::TIME_W-1:0]       preset;
    logic                             done;

    modport ctl (output load, output preset, input done);
    modport tmr (input load, input preset, output done);
endinterface : mbs_tmr_if

/* File: verilog/mbs_hold_timer.sv */
// hold timer counting in 10 ms steps, one-cycle done pulse
module mbs_hold_timer #(
    parameter int unsigned TICK_CYC = mbs_pkg::TIME_TICK_CYC
) (
    // clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    // sequencer side
    mbs_tmr_if.tmr    tmr
);
    localparam int unsigned PW = $clog2(TICK_CYC + 1);

    logic [PW-1:0]                presc_reg;
    logic [mbs_pkg::TIME_W-1:0]   left_reg;
    logic                         active_reg;
    logic                         done_reg;

    wire  tick_end = (presc_reg == PW'(TICK_CYC - 1));
    wire  expired  = active_reg && (left_reg == '0);

    // refuse a tick length the prescaler cannot count
    if (TICK_CYC < 1) begin : g_bad_tick
        $error("tick length must be at least one cycle");
    end

    // prescaler and step counter; load restarts both
    always_ff @(posedge i_core_clk) begin
        if (i_rst || tmr.load) begin
            presc_reg  <= '0;
            left_reg   <= i_rst ? '0 : tmr.preset;
            active_reg <= !i_rst;
        end else if (active_reg) begin
            presc_reg  <= tick_end ? '0 : presc_reg + PW'(1);
            if (tick_end && left_reg != '0) begin
                left_reg <= left_reg - (mbs_pkg::TIME_W)'(1);
            end
            if (expired) active_reg <= 1'b0;
        end
    end

    // done pulse
    always_ff @(posedge i_core_clk) begin
        done_reg <= !i_rst && !tmr.load && expired;
    end

    assign tmr.done = done_reg;
endmodule : mbs_hold_timer

/* File: verilog/mbs_brake_seq.sv */
// brake release sequencer: opening, opening hold, closing, closing hold
// Overview of operation
// - sequence runs only when an aux output carries the brake function
// - brake output stays off while motor auto-tuning runs
// - after excitation, open brake and hold for opening time, max 30.00 s
// - during opening time, speed reference is the opening speed
// - open only once output current exceeds threshold percent of magnetising
// - while stopping, release brake output at the closing speed
// - closing hold time follows before the stop sequence ends
module mbs_brake_seq #(
    parameter int unsigned TICK_CYC = mbs_pkg::TIME_TICK_CYC
) (
    // clock and reset
    input  wire logic                         i_core_clk,
    input  wire logic                         i_rst,
    // drive status
    input  wire logic                         i_brake_fn_assigned,
    input  wire logic                         i_autotune_active,
    input  wire logic                         i_trip_or_block,
    input  wire logic                         i_run_cmd,
    input  wire logic                         i_excitation_done,
    input  wire logic [mbs_pkg::PCT_W-1:0]    i_out_current_pct,
    input  wire logic [mbs_pkg::SPD_W-1:0]    i_motor_speed,
    // settings
    input  wire logic [mbs_pkg::TIME_W-1:0]   i_brake_open_hold_time,
    input  wire logic [mbs_pkg::SPD_W-1:0]    i_brake_open_speed,
    input  wire logic [mbs_pkg::PCT_W-1:0]    i_brake_release_current_pct,
    input  wire logic [mbs_pkg::TIME_W-1:0]   i_brake_close_hold_time,
    input  wire logic [mbs_pkg::SPD_W-1:0]    i_brake_close_speed,
    // brake and speed reference
    output logic                              o_brake_release,
    output logic                              o_speed_ref_valid,
    output logic [mbs_pkg::SPD_W-1:0]         o_speed_ref,
    // status
    output logic                              o_seq_busy,
    output logic                              o_stop_done
);
    mbs_pkg::mbs_state_t state_reg, state_next;
    logic                        brake_reg;
    logic                        ref_valid_reg;
    logic [mbs_pkg::SPD_W-1:0]   ref_reg;
    logic                        stop_done_reg;
    logic                        busy_reg;

    mbs_tmr_if tif ();

    mbs_hold_timer #(.TICK_CYC(TICK_CYC)) u_timer (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .tmr        (tif)
    );

    // settings clamped to their ranges
    wire [mbs_pkg::TIME_W-1:0] open_time  =
        (i_brake_open_hold_time > mbs_pkg::TIME_MAX) ? mbs_pkg::TIME_MAX
                                                     : i_brake_open_hold_time;
    wire [mbs_pkg::TIME_W-1:0] close_time =
        (i_brake_close_hold_time > mbs_pkg::TIME_MAX) ? mbs_pkg::TIME_MAX
                                                      : i_brake_close_hold_time;
    wire [mbs_pkg::SPD_W-1:0]  open_spd   =
        (i_brake_open_speed > mbs_pkg::SPD_MAX) ? mbs_pkg::SPD_MAX
                                                : i_brake_open_speed;
    wire [mbs_pkg::SPD_W-1:0]  close_spd  =
        (i_brake_close_speed > mbs_pkg::SPD_MAX) ? mbs_pkg::SPD_MAX
                                                 : i_brake_close_speed;
    wire [mbs_pkg::PCT_W-1:0]  rel_pct    =
        (i_brake_release_current_pct > mbs_pkg::PCT_MAX) ? mbs_pkg::PCT_MAX
                                               : i_brake_release_current_pct;

    // abort and step conditions
    wire force_off  = !i_brake_fn_assigned || i_autotune_active
                      || i_trip_or_block;
    wire current_ok = i_out_current_pct > rel_pct;
    wire open_go    = i_excitation_done && current_ok;
    wire below_cls  = i_motor_speed <= close_spd;

    wire st_excite  = (state_reg == mbs_pkg::ST_EXCITE);
    wire st_open    = (state_reg == mbs_pkg::ST_OPEN_HOLD);
    wire st_closing = (state_reg == mbs_pkg::ST_CLOSING);
    wire st_chold   = (state_reg == mbs_pkg::ST_CLOSE_HOLD);

    // timer starts on entry to either hold state
    assign tif.load   = (st_excite && open_go && i_run_cmd && !force_off)
                        || (st_closing && below_cls && !force_off);
    assign tif.preset = st_excite ? open_time : close_time;

    // next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            mbs_pkg::ST_IDLE:
                if (i_run_cmd) state_next = mbs_pkg::ST_EXCITE;
            mbs_pkg::ST_EXCITE:
                if (!i_run_cmd) state_next = mbs_pkg::ST_IDLE;
                else if (open_go) state_next = mbs_pkg::ST_OPEN_HOLD;
            mbs_pkg::ST_OPEN_HOLD:
                if (!i_run_cmd) state_next = mbs_pkg::ST_CLOSING;
                else if (tif.done) state_next = mbs_pkg::ST_RUN;
            mbs_pkg::ST_RUN:
                if (!i_run_cmd) state_next = mbs_pkg::ST_CLOSING;
            mbs_pkg::ST_CLOSING:
                if (below_cls) state_next = mbs_pkg::ST_CLOSE_HOLD;
            mbs_pkg::ST_CLOSE_HOLD:
                if (tif.done) state_next = mbs_pkg::ST_IDLE;
            default:
                state_next = mbs_pkg::ST_IDLE;
        endcase
        if (force_off) state_next = mbs_pkg::ST_IDLE;
    end

    // decoded targets of the next state; end of stop from the closing hold state and timer done
    wire enter_open = (state_next == mbs_pkg::ST_OPEN_HOLD);
    wire brake_next = enter_open
                      || (state_next == mbs_pkg::ST_RUN)
                      || (state_next == mbs_pkg::ST_CLOSING);
    wire stop_end   = st_chold && tif.done && !force_off;

    // state register
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_reg <= mbs_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // brake output and busy flag follow the next state, so both
    // switch on the same edge as the state itself
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            brake_reg <= 1'b0;
            busy_reg  <= 1'b0;
        end else begin
            brake_reg <= brake_next;
            busy_reg  <= (state_next != mbs_pkg::ST_IDLE);
        end
    end

    // speed reference override, zero outside the opening hold
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ref_valid_reg <= 1'b0;
            ref_reg       <= '0;
        end else begin
            ref_valid_reg <= enter_open;
            ref_reg       <= enter_open ? open_spd : '0;
        end
    end

    // end-of-stop pulse; an abort by force-off gives none
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            stop_done_reg <= 1'b0;
        end else begin
            stop_done_reg <= stop_end;
        end
    end

    assign o_brake_release   = brake_reg;
    assign o_speed_ref_valid = ref_valid_reg;
    assign o_speed_ref       = ref_reg;
    assign o_seq_busy        = busy_reg;
    assign o_stop_done       = stop_done_reg;

    // checks
    brake_fn_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        !i_brake_fn_assigned |=> !o_brake_release)
        else $error("brake output on without brake function");
    autotune_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        i_autotune_active |=> !o_brake_release)
        else $error("brake output on during auto-tuning");
    excite_first_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        $rose(o_brake_release) |-> $past(i_excitation_done))
        else $error("brake opened before excitation");
    shut_idle_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (!o_seq_busy || st_excite) |-> !o_brake_release)
        else $error("brake open in idle or excitation");
    open_ref_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        $rose(o_brake_release) |-> o_speed_ref_valid
        && o_speed_ref == $past(open_spd))
        else $error("opening speed not commanded");
    ref_idle_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        !o_speed_ref_valid |-> o_speed_ref == '0)
        else $error("speed reference left outside opening hold");
    ref_brake_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        o_speed_ref_valid |-> o_brake_release)
        else $error("opening speed with brake shut");
    open_current_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        $rose(o_brake_release) |-> $past(current_ok))
        else $error("brake opened below current threshold");
    close_speed_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        $fell(o_brake_release) && !$past(force_off) |-> $past(below_cls))
        else $error("brake closed above closing speed");
    close_load_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        st_closing && below_cls && !force_off |=> st_chold
        && !o_brake_release)
        else $error("brake kept open below closing speed");
    close_hold_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        o_stop_done |-> !o_brake_release && $past(st_chold, 1)
        && $past(tif.done))
        else $error("stop ended outside closing hold");
    done_pulse_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        o_stop_done |-> !o_seq_busy ##1 !o_stop_done)
        else $error("stop pulse longer than one cycle");
    trip_off_a: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        i_trip_or_block |=> !o_brake_release && !o_seq_busy)
        else $error("brake held through trip");

    open_seen_c: cover property (@(posedge i_core_clk) disable iff (i_rst)
        $rose(o_brake_release));
    stop_seen_c: cover property (@(posedge i_core_clk) disable iff (i_rst)
        o_stop_done);
    trip_seen_c: cover property (@(posedge i_core_clk) disable iff (i_rst)
        o_brake_release && i_trip_or_block);
    early_stop_c: cover property (@(posedge i_core_clk) disable iff (i_rst)
        st_open && !i_run_cmd && !force_off);
    clamp_seen_c: cover property (@(posedge i_core_clk) disable iff (i_rst)
        $rose(o_brake_release) && o_speed_ref == mbs_pkg::SPD_MAX);
endmodule : mbs_brake_seq

/* File: dv/mbs_brake_actuator.sv */
// spring-applied holding brake model, slow coil in both directions
module mbs_brake_actuator #(
    parameter int unsigned DLY = 3
) (
    // clock
    input  wire logic i_core_clk,
    // release line in, coil state out
    input  wire logic i_release,
    output logic      o_open
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned cnt      = 0;
    logic        open_reg = 1'b0;
    // coil follows the release line only after DLY cycles
    always @(posedge i_core_clk) begin
        if (open_reg == i_release) begin
            cnt <= 0;
        end else if (cnt + 1 >= DLY) begin
            open_reg <= i_release;
            cnt      <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
    assign o_open = open_reg;
endmodule : mbs_brake_actuator

/* File: dv/tb_motor_brake_sequencer.sv */
// self-checking bench for the brake sequencer
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_motor_brake_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned TICK = 4;
    logic        clk = 0, rst = 1, fn = 0, tune = 0, trip = 0;
    logic        run = 0, exc = 0, brake, ref_v, busy, done, opened;
    logic [10:0] cur = 0, pct = 0;
    logic [12:0] spd = 0, spd_o = 0, spd_c = 0, sref;
    logic [11:0] t_o = 0, t_c = 1;
    int          n_fail = 0, n_tests = 0, seed = 80852, n;
    always #4 clk = ~clk;
    mbs_brake_seq #(.TICK_CYC(TICK)) dut (
        .i_core_clk(clk), .i_rst(rst), .i_brake_fn_assigned(fn),
        .i_autotune_active(tune), .i_trip_or_block(trip), .i_run_cmd(run),
        .i_excitation_done(exc), .i_out_current_pct(cur),
        .i_motor_speed(spd), .i_brake_open_hold_time(t_o),
        .i_brake_open_speed(spd_o), .i_brake_release_current_pct(pct),
        .i_brake_close_hold_time(t_c), .i_brake_close_speed(spd_c),
        .o_brake_release(brake), .o_speed_ref_valid(ref_v),
        .o_speed_ref(sref), .o_seq_busy(busy), .o_stop_done(done));
    mbs_brake_actuator act (.i_core_clk(clk), .i_release(brake),
        .o_open(opened));
    // expected hold length in clock cycles
    function automatic int hold(logic [11:0] t);
        return int'(t) * TICK;
    endfunction : hold
    // expected opening speed after the range clamp
    function automatic logic [12:0] lim_spd(logic [12:0] s);
        return (s > mbs_pkg::SPD_MAX) ? mbs_pkg::SPD_MAX : s;
    endfunction : lim_spd
    function automatic logic sel(int w);
        if (w == 0) return brake;
        if (w == 1) return done;
        return busy;
    endfunction : sel
    task automatic conclude();
        if (n_fail == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    // bounded wait for a status bit to reach a level
    task automatic wait_on(input int w, input logic v, input int lim);
        n = 0;
        while (sel(w) !== v) begin
            if (n >= lim) begin
                n_fail++;
                $display("wrong value %s exp %0h got %0h", "wait", v, sel(w));
                conclude();
            end
            tick(1);
            n++;
        end
    endtask : wait_on
    // one full open, run and stop sequence, optional trip in run
    task automatic seq(input logic do_trip);
        spd = spd_c + 13'h00A;
        cur = pct + 11'h001;
        exc = 1'b1;
        run = 1'b1;
        wait_on(0, 1'b1, 4);
        `CHK("ref valid", 1'b1, ref_v)
        `CHK("open speed", lim_spd(spd_o), sref)
        n = 0;
        while (ref_v === 1'b1 && n < hold(t_o) + 10) begin
            tick(1);
            n++;
        end
        `CHK("open hold", 1'b1, n >= hold(t_o) && n <= hold(t_o) + 4)
        `CHK("run brake", 1'b1, brake)
        `CHK("run ref", 13'h0000, sref)
        if (do_trip) begin
            trip = 1'b1;
            tick(1);
            `CHK("trip brake", 1'b0, brake)
            tick(3);
            `CHK("trip busy", 1'b0, busy)
            trip = 1'b0;
            run = 1'b0;
            tick(1);
            return;
        end
        run = 1'b0;
        tick(3);
        `CHK("above close", 1'b1, brake)
        spd = spd_c;
        wait_on(0, 1'b0, 3);
        `CHK("close busy", 1'b1, busy)
        wait_on(1, 1'b1, hold(t_c) + 6);
        `CHK("close hold", 1'b1, n >= hold(t_c))
        `CHK("brake shut", 1'b0, opened)
        tick(1);
        `CHK("done pulse", 1'b0, done)
        `CHK("idle", 1'b0, busy)
    endtask : seq
    initial begin
        tick(4);
        rst = 1'b0;
        exc = 1'b1;
        pct = mbs_pkg::PCT_RESET;
        cur = mbs_pkg::PCT_RESET + 11'h001;
        // each force-off condition refuses the sequence
        for (int k = 0; k < 3; k++) begin
            fn = (k != 0);
            tune = (k == 1);
            trip = (k == 2);
            run = 1'b1;
            tick(10);
            `CHK("forced brake", 1'b0, brake)
            `CHK("forced busy", 1'b0, busy)
            run = 1'b0;
            tick(2);
        end
        {fn, tune, trip} = 3'b100;
        // current equal to threshold must not open
        cur = pct;
        run = 1'b1;
        tick(10);
        `CHK("at threshold", 1'b0, brake)
        run = 1'b0;
        wait_on(2, 1'b0, 4);
        // run dropped inside the opening hold goes straight to closing
        t_o   = 12'h005;
        spd_c = 13'h0064;
        spd   = 13'h00C8;
        cur   = pct + 11'h001;
        run   = 1'b1;
        wait_on(0, 1'b1, 4);
        run = 1'b0;
        tick(2);
        `CHK("early ref", 1'b0, ref_v)
        `CHK("early brake", 1'b1, brake)
        spd = spd_c;
        wait_on(1, 1'b1, hold(t_c) + 8);
        `CHK("early close", 1'b1, n >= hold(t_c))
        for (int i = 0; i < 8; i++) begin
            t_o = (i == 0) ? 12'h000 : 12'($unsigned($random(seed)) % 8);
            t_c = 12'(1 + $unsigned($random(seed)) % 7);
            spd_o = 13'($unsigned($random(seed)) % 5001);
            spd_c = (i == 1) ? 13'h1388 : 13'($unsigned($random(seed)) % 5001);
            pct = 11'($unsigned($random(seed)) % 1500);
            // backlash cure: closing speed raised stepwise, time with it
            if (i >= 2 && i <= 4) begin
                spd_c = 13'(i) * 13'h064;
                t_c   = 12'(i);
            end
            // out-of-range opening speed must be clamped
            if (i == 3) begin
                spd_o = 13'h1FFF;
            end
            seq(i == 7);
        end
        conclude();
    end
endmodule : tb_motor_brake_sequencer
